// *** hw/moid_datapath.sv ***
// Purpose: Executes seven accumulator/file-register operations, one per instruction cycle.
// Assumes: The register operand arrives in the same cycle as its decoded operation.
// Notes:   A zero result of a skip operation turns the next issued operation into an idle slot.
//
// Functional notes
// - Decrement skip: register minus one to accumulator or register, flags untouched.
// - Decrement skip with zero result turns the next instruction into an idle slot.
// - Increment skip: register plus one to accumulator or register, flags untouched.
// - Increment skip with zero result turns the next instruction into an idle slot.
// - OR literal: accumulator OR literal into accumulator, zero flag updated.
// - Load literal: literal into accumulator, flags untouched.
// - OR register: accumulator OR register to chosen destination, zero flag updated.
// - Store accumulator: accumulator copied into addressed register, flags untouched.
// - Copy register: register to chosen destination, zero flag updated.
// - Copy register to itself rewrites the value and still updates zero flag.
`include "moid_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module moid_datapath #(
    parameter int DATA_W = `MOID_DATA_W,
    parameter int ADDR_W = `MOID_ADDR_W
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Decoded instruction from the fetch sequencer.
    input wire logic issue_i,
    input wire moid_pkg::moid_op_e op_i,
    input wire logic [ADDR_W-1:0] file_addr_i,
    input wire logic target_bit_i,
    input wire logic [DATA_W-1:0] literal_i,
    // Register operand read from the data memory file.
    input wire logic [DATA_W-1:0] reg_rd_data_i,
    // Write port towards the data memory file.
    output logic reg_wr_en_o,
    output logic [ADDR_W-1:0] reg_wr_addr_o,
    output logic [DATA_W-1:0] reg_wr_data_o,
    // Core state.
    output logic [DATA_W-1:0] acc_o,
    output logic result_null_flag_o,
    output logic skip_pending_o,
    output logic idle_slot_o
);
    import moid_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The data width is fixed and the address width bounded by the instruction encoding.
    if (DATA_W != 8) begin : g_bad_data_w
        $error("DATA_W must be 8");
    end
    if (ADDR_W < 1 || ADDR_W > 7) begin : g_bad_addr_w
        $error("ADDR_W must be 1 to 7");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Zero detect, shared by the flag update and the skip decision.
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        is_zero = (v == '0);
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] acc_reg, acc_next;
    logic zero_reg, zero_next;
    logic skip_reg, skip_next;
    logic idle_reg, idle_next;
    logic wr_en_reg, wr_en_next;
    logic [ADDR_W-1:0] wr_addr_reg, wr_addr_next;
    logic [DATA_W-1:0] wr_data_reg, wr_data_next;
    logic [DATA_W-1:0] result;
    logic to_reg;
    logic set_zero;
    logic arm_skip;
    logic execute;

    // Next-state computation for one issued operation.
    always_comb begin
        acc_next = acc_reg;
        zero_next = zero_reg;
        skip_next = skip_reg;
        idle_next = 1'b0;
        wr_en_next = 1'b0;
        wr_addr_next = wr_addr_reg;
        wr_data_next = wr_data_reg;
        result = reg_rd_data_i;
        to_reg = 1'b0;
        set_zero = 1'b0;
        arm_skip = 1'b0;
        // A pending skip swallows the next issued operation, whatever it is.
        execute = issue_i && !skip_reg;
        if (issue_i && skip_reg) begin
            skip_next = 1'b0;
            idle_next = 1'b1;
        end
        if (execute) begin
            case (op_i)
                OP_DEC_SKIP: begin
                    result = reg_rd_data_i - 8'h01;
                    to_reg = (target_bit_i == `MOID_TARGET_REG);
                    arm_skip = 1'b1;
                end
                OP_INC_SKIP: begin
                    result = reg_rd_data_i + 8'h01;
                    to_reg = (target_bit_i == `MOID_TARGET_REG);
                    arm_skip = 1'b1;
                end
                OP_OR_LIT: begin
                    result = acc_reg | literal_i;
                    set_zero = 1'b1;
                end
                OP_LOAD_LIT: begin
                    result = literal_i;
                end
                OP_OR_REG: begin
                    result = acc_reg | reg_rd_data_i;
                    to_reg = (target_bit_i == `MOID_TARGET_REG);
                    set_zero = 1'b1;
                end
                OP_STORE_ACC: begin
                    result = acc_reg;
                    to_reg = 1'b1;
                end
                OP_COPY_REG: begin
                    // Writing back the same value lets software test a register for zero.
                    result = reg_rd_data_i;
                    to_reg = (target_bit_i == `MOID_TARGET_REG);
                    set_zero = 1'b1;
                end
                default: begin
                    result = reg_rd_data_i;
                end
            endcase
            if (op_i != OP_NONE) begin
                if (to_reg) begin
                    wr_en_next = 1'b1;
                    wr_addr_next = file_addr_i;
                    wr_data_next = result;
                end else begin
                    acc_next = result;
                end
            end
            if (set_zero) begin
                zero_next = is_zero(result);
            end
            if (arm_skip) begin
                skip_next = is_zero(result);
            end
        end
    end

    // Registers only; reset gives a clean accumulator and no pending skip.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            acc_reg <= `MOID_ACC_RST;
            zero_reg <= `MOID_ZERO_RST;
            skip_reg <= 1'b0;
            idle_reg <= 1'b0;
            wr_en_reg <= 1'b0;
            wr_addr_reg <= '0;
            wr_data_reg <= '0;
        end else begin
            acc_reg <= acc_next;
            zero_reg <= zero_next;
            skip_reg <= skip_next;
            idle_reg <= idle_next;
            wr_en_reg <= wr_en_next;
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
        end
    end

    // Outputs straight from flip-flops.
    assign acc_o = acc_reg;
    assign result_null_flag_o = zero_reg;
    assign skip_pending_o = skip_reg;
    assign idle_slot_o = idle_reg;
    assign reg_wr_en_o = wr_en_reg;
    assign reg_wr_addr_o = wr_addr_reg;
    assign reg_wr_data_o = wr_data_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic live;
    assign live = issue_i && !skip_reg;

    AST_DEC_ACC: assert property (live && op_i == OP_DEC_SKIP && !target_bit_i
        |=> acc_o == $past(reg_rd_data_i) - 8'h01 && $stable(result_null_flag_o))
        else $error("decrement to accumulator wrong");
    AST_DEC_SKIP: assert property (live && op_i == OP_DEC_SKIP && reg_rd_data_i == 8'h01
        ##1 issue_i |=> idle_slot_o && !skip_pending_o && !reg_wr_en_o)
        else $error("zero decrement did not idle the next slot");
    AST_INC_REG: assert property (live && op_i == OP_INC_SKIP && target_bit_i
        |=> reg_wr_en_o && reg_wr_data_o == $past(reg_rd_data_i) + 8'h01
            && reg_wr_addr_o == $past(file_addr_i) && $stable(acc_o))
        else $error("increment to register wrong");
    AST_INC_NOSKIP: assert property (live && op_i == OP_INC_SKIP && reg_rd_data_i != 8'hFF
        |=> !skip_pending_o)
        else $error("nonzero increment armed a skip");
    AST_OR_LIT: assert property (live && op_i == OP_OR_LIT
        |=> acc_o == ($past(acc_o) | $past(literal_i))
            && result_null_flag_o == (acc_o == 8'h00))
        else $error("or literal wrong");
    AST_LOAD: assert property (live && op_i == OP_LOAD_LIT
        |=> acc_o == $past(literal_i) && $stable(result_null_flag_o) && !reg_wr_en_o)
        else $error("load literal wrong");
    AST_OR_REG: assert property (live && op_i == OP_OR_REG && target_bit_i
        |=> reg_wr_data_o == ($past(acc_o) | $past(reg_rd_data_i)) && reg_wr_en_o)
        else $error("or register wrong");
    AST_STORE: assert property (live && op_i == OP_STORE_ACC
        |=> reg_wr_en_o && reg_wr_data_o == $past(acc_o) && $stable(result_null_flag_o))
        else $error("store accumulator wrong");
    AST_COPY_ACC: assert property (live && op_i == OP_COPY_REG && !target_bit_i
        |=> acc_o == $past(reg_rd_data_i) && !reg_wr_en_o)
        else $error("copy register to accumulator wrong");
    AST_COPY_TEST: assert property (live && op_i == OP_COPY_REG && target_bit_i
        |=> reg_wr_data_o == $past(reg_rd_data_i) && $stable(acc_o)
            && result_null_flag_o == ($past(reg_rd_data_i) == 8'h00))
        else $error("register zero test wrong");
    AST_ZERO_FLAG: assert property (live && op_i == OP_OR_REG && !target_bit_i
        |=> result_null_flag_o == (acc_o == 8'h00))
        else $error("zero flag mismatch");

    COV_DEC_SKIP: cover property (live && op_i == OP_DEC_SKIP ##1 issue_i ##1 idle_slot_o);
    COV_INC_SKIP: cover property (live && op_i == OP_INC_SKIP && reg_rd_data_i == 8'hFF);
    COV_ZERO_TEST: cover property (live && op_i == OP_COPY_REG && target_bit_i
        && reg_rd_data_i == 8'h00);
    COV_STORE: cover property (live && op_i == OP_STORE_ACC);

endmodule

`default_nettype wire

// *** hw/moid_defines.svh ***
// Purpose: Shared constants of the move, OR and inc/dec-skip datapath.
// Assumes: Included by bare name from the package and the datapath.
// Notes:   Definitions only.
`ifndef MOID_DEFINES_SVH
`define MOID_DEFINES_SVH

// ----------------------------------------------------------------------
// Reset values, destination encoding and widths
// ----------------------------------------------------------------------
`define MOID_ACC_RST 8'h00
`define MOID_ZERO_RST 1'b0
`define MOID_TARGET_ACC 1'b0
`define MOID_TARGET_REG 1'b1
`define MOID_DATA_W 8
`define MOID_ADDR_W 7

`endif

// *** hw/moid_pkg.sv ***
// Purpose: Types of the move, OR and inc/dec-skip datapath.
// Assumes: Compiled before the datapath.
// Notes:   Operation codes come from the fetch sequencer already decoded.
`include "moid_defines.svh"

package moid_pkg;

    // ------------------------------------------------------------------
    // Decoded operations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE,
        OP_DEC_SKIP,
        OP_INC_SKIP,
        OP_OR_LIT,
        OP_LOAD_LIT,
        OP_OR_REG,
        OP_STORE_ACC,
        OP_COPY_REG
    } moid_op_e;

endpackage

// *** tb/moid_datapath_tb_top.sv ***
// Purpose: Self-checking bench for the datapath.
// Assumes: The file model answers reads in the same cycle.
// Notes: A flag result is chosen so that a wrongly updated flag differs.
`timescale 1ns/100ps
`default_nettype none
module moid_datapath_tb_top;
    import moid_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic issue_i = 1'b0;
    moid_op_e op_i = OP_NONE;
    logic [6:0] addr_i = 7'h00;
    logic tgt_i = 1'b0;
    logic [7:0] lit_i = 8'h00;
    logic [7:0] rd_w, wd_w, acc_w;
    logic [6:0] wa_w;
    logic we_w, z_w, sk_w, idle_w;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    moid_datapath dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .issue_i(issue_i), .op_i(op_i),
        .file_addr_i(addr_i), .target_bit_i(tgt_i), .literal_i(lit_i), .reg_rd_data_i(rd_w),
        .reg_wr_en_o(we_w), .reg_wr_addr_o(wa_w), .reg_wr_data_o(wd_w), .acc_o(acc_w),
        .result_null_flag_o(z_w), .skip_pending_o(sk_w), .idle_slot_o(idle_w));
    moid_file_model mem_u (.clk_i(clk_i), .addr_i(addr_i), .rd_data_o(rd_w),
        .wr_en_i(we_w), .wr_addr_i(wa_w), .wr_data_i(wd_w));
    // Clock of 40 ns.
    always #20 clk_i = ~clk_i;
    // -------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // One operation; returns just after the edge that took it.
    task automatic run(input moid_op_e o, input logic [6:0] a, input logic t,
        input logic [7:0] l);
        @(posedge clk_i);
        issue_i <= 1'b1;
        op_i <= o;
        addr_i <= a;
        tgt_i <= t;
        lit_i <= l;
        @(posedge clk_i);
        issue_i <= 1'b0;
        op_i <= OP_NONE;
        #1;
    endtask
    // Two operations back to back; returns just after the edge that took the second.
    task automatic run_two(input moid_op_e o1, input logic [6:0] a1, input logic t1,
        input moid_op_e o2, input logic [6:0] a2);
        @(posedge clk_i);
        issue_i <= 1'b1;
        op_i <= o1;
        addr_i <= a1;
        tgt_i <= t1;
        @(posedge clk_i);
        op_i <= o2;
        addr_i <= a2;
        @(posedge clk_i);
        issue_i <= 1'b0;
        op_i <= OP_NONE;
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic t_store;
        run(OP_LOAD_LIT, 7'h00, 1'b0, 8'h01);
        chk("acc", 8'h01, acc_w);
        run(OP_STORE_ACC, 7'h7F, 1'b0, 8'h00);
        chk("wr_en", 8'h01, {7'h00, we_w});
        chk("wr_addr", 8'h7F, {1'b0, wa_w});
        chk("wr_data", 8'h01, wd_w);
        chk("flag", 8'h00, {7'h00, z_w});
    endtask
    // Zero result into the register, then a swallowed literal load.
    task automatic t_dec;
        run(OP_DEC_SKIP, 7'h7F, 1'b1, 8'h00);
        chk("wr_data", 8'h00, wd_w);
        chk("acc", 8'h01, acc_w);
        chk("flag", 8'h00, {7'h00, z_w});
        chk("skip", 8'h01, {7'h00, sk_w});
        run(OP_LOAD_LIT, 7'h00, 1'b0, 8'h55);
        chk("idle", 8'h01, {7'h00, idle_w});
        chk("acc", 8'h01, acc_w);
        run(OP_DEC_SKIP, 7'h7F, 1'b0, 8'h00);
        chk("acc", 8'hFF, acc_w);
        chk("wr_en", 8'h00, {7'h00, we_w});
        chk("skip", 8'h00, {7'h00, sk_w});
        run(OP_LOAD_LIT, 7'h00, 1'b0, 8'h33);
        chk("acc", 8'h33, acc_w);
        // Back to back: the zero decrement swallows the very next operation.
        run(OP_LOAD_LIT, 7'h00, 1'b0, 8'h01);
        run(OP_STORE_ACC, 7'h7F, 1'b0, 8'h00);
        run_two(OP_DEC_SKIP, 7'h7F, 1'b1, OP_LOAD_LIT, 7'h00);
        chk("idle", 8'h01, {7'h00, idle_w});
        chk("skip", 8'h00, {7'h00, sk_w});
        chk("wr_en", 8'h00, {7'h00, we_w});
        chk("acc", 8'h01, acc_w);
        chk("wr_data", 8'h00, wd_w);
    endtask
    task automatic t_orl;
        run(OP_LOAD_LIT, 7'h00, 1'b0, 8'h00);
        run(OP_OR_LIT, 7'h00, 1'b0, 8'h00);
        chk("flag", 8'h01, {7'h00, z_w});
        run(OP_OR_LIT, 7'h00, 1'b0, 8'h81);
        chk("acc", 8'h81, acc_w);
        chk("flag", 8'h00, {7'h00, z_w});
    endtask
    // Flag is set first so that a nonzero result would clear it.
    task automatic t_inc;
        run(OP_LOAD_LIT, 7'h00, 1'b0, 8'h00);
        run(OP_OR_LIT, 7'h00, 1'b0, 8'h00);
        run(OP_LOAD_LIT, 7'h00, 1'b0, 8'hFF);
        chk("flag", 8'h01, {7'h00, z_w});
        run(OP_INC_SKIP, 7'h11, 1'b1, 8'h00);
        chk("wr_data", 8'hA6, wd_w);
        chk("flag", 8'h01, {7'h00, z_w});
        chk("skip", 8'h00, {7'h00, sk_w});
        run(OP_STORE_ACC, 7'h10, 1'b0, 8'h00);
        run(OP_INC_SKIP, 7'h10, 1'b0, 8'h00);
        chk("acc", 8'h00, acc_w);
        chk("skip", 8'h01, {7'h00, sk_w});
        run(OP_STORE_ACC, 7'h11, 1'b0, 8'h00);
        chk("wr_en", 8'h00, {7'h00, we_w});
        chk("idle", 8'h01, {7'h00, idle_w});
    endtask
    task automatic t_orr_copy;
        run(OP_LOAD_LIT, 7'h00, 1'b0, 8'h5A);
        run(OP_OR_REG, 7'h11, 1'b1, 8'h00);
        chk("wr_data", 8'hFE, wd_w);
        chk("acc", 8'h5A, acc_w);
        run(OP_COPY_REG, 7'h7F, 1'b1, 8'h00);
        chk("wr_data", 8'h00, wd_w);
        chk("flag", 8'h01, {7'h00, z_w});
        run(OP_COPY_REG, 7'h11, 1'b0, 8'h00);
        chk("acc", 8'hFE, acc_w);
        chk("flag", 8'h00, {7'h00, z_w});
        // OR into the accumulator with a zero result sets the flag again.
        run(OP_LOAD_LIT, 7'h00, 1'b0, 8'h00);
        run(OP_OR_REG, 7'h7F, 1'b0, 8'h00);
        chk("acc", 8'h00, acc_w);
        chk("wr_en", 8'h00, {7'h00, we_w});
        chk("flag", 8'h01, {7'h00, z_w});
    endtask
    // Main sequence after 12 cycles of reset.
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk("acc", 8'h00, acc_w);
        t_store();
        t_dec();
        t_orl();
        t_inc();
        t_orr_copy();
        report_and_stop();
    end
    // Cut a hang short well past the expected run length.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fail_count++;
            report_and_stop();
        end
    end
endmodule
`default_nettype wire

// *** tb/moid_file_model.sv ***
// Purpose: Data memory file model at the far side of the datapath.
// Assumes: Read is combinational, write lands on the clock edge.
// Notes: Filled with A5 so that a lost or stray write shows up.
`timescale 1ns/100ps
`default_nettype none
module moid_file_model (
    // Clock.
    input wire logic clk_i,
    // Read and write ports.
    input wire logic [6:0] addr_i,
    output logic [7:0] rd_data_o,
    input wire logic wr_en_i,
    input wire logic [6:0] wr_addr_i,
    input wire logic [7:0] wr_data_i
);
    logic [7:0] mem_r [0:127];
    // Marker fill, so untouched places are known.
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem_r[i] = 8'hA5;
        end
    end
    // Read follows the address in the same cycle.
    assign rd_data_o = mem_r[addr_i];
    // Write pulse lasts one cycle, so one edge takes it.
    always @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
    end
endmodule
`default_nettype wire
